//--- verilog/ess_map.svh
// Register map, field positions, reset values and timing constants of the supervisor
`ifndef ESS_MAP_SVH
`define ESS_MAP_SVH

// Timing
`define ESS_CLK_MHZ      100
`define ESS_TICK_MS      1000
`define ESS_US_PER_MS    1000
`define ESS_MIN_LAST_SEC 6'd59
`define ESS_PCT          11'sd100

// Register indices, byte address is four times the index
`define ESS_N_CFG  9
`define ESS_I_NOM1 4'd0
`define ESS_I_NOM2 4'd1
`define ESS_I_NOM3 4'd2
`define ESS_I_LIM  4'd3
`define ESS_I_SPD  4'd4
`define ESS_I_CHG  4'd5
`define ESS_I_STC  4'd6
`define ESS_I_RUN  4'd7
`define ESS_I_STP  4'd8
`define ESS_I_STAT 4'd9
`define ESS_F_IDX  5:2
`define ESS_F_LO   1:0
`define ESS_F_HI   7:6

// Reset values
`define ESS_RV_NOM1 32'h0000_05dc
`define ESS_RV_NOM2 32'h0000_0708
`define ESS_RV_NOM3 32'h0000_0708
`define ESS_RV_LIM  32'h0f0a_f1f6
`define ESS_RV_SPD  32'h0000_030a
`define ESS_RV_CHG  32'h0228_003c
`define ESS_RV_STC  32'h0adb_0001
`define ESS_RV_RUN  32'h00f0_0004
`define ESS_RV_STP  32'h0000_050a

// Fields
`define ESS_F_NOM  15:0
`define ESS_F_LW   7:0
`define ESS_F_LSD  15:8
`define ESS_F_HW   23:16
`define ESS_F_HSD  31:24
`define ESS_F_OS   7:0
`define ESS_F_SFT  11:8
`define ESS_F_LEN  12
`define ESS_F_ACT  14:13
`define ESS_F_LT   23:16
`define ESS_F_CW   8:0
`define ESS_F_CSD  24:16
`define ESS_F_CFT  31:25
`define ESS_F_DLY  9:0
`define ESS_F_PRH  14:10
`define ESS_F_CRK  18:15
`define ESS_F_NST  21:19
`define ESS_F_PRA  22
`define ESS_F_STA  23
`define ESS_F_WAIT 31:24
`define ESS_F_HT   7:0
`define ESS_F_HTMP 15:8
`define ESS_F_HM   16
`define ESS_F_COOL 26:17
`define ESS_F_ST   6:0
`define ESS_F_CH   15:8

// Frequency select and lost-signal actions
`define ESS_FSEL_2 2'h1
`define ESS_FSEL_3 2'h2
`define ESS_ACT_SD 2'h0
`define ESS_ACT_LD 2'h1
`define ESS_ACT_WN 2'h2

// Alarm bits in the status register
`define ESS_N_ALM 9
`define ESS_AL_USW 0
`define ESS_AL_USD 1
`define ESS_AL_OSW 2
`define ESS_AL_OSD 3
`define ESS_AL_LOS 4
`define ESS_AL_CHW 5
`define ESS_AL_CHD 6
`define ESS_AL_SFL 7
`define ESS_AL_PFL 8

`endif

//--- verilog/ess_pkg.sv
// Types of the engine start/stop supervisor
package ess_pkg;
    typedef enum logic [3:0] {
        S_IDLE, S_DELAY, S_PREHEAT, S_CRANK, S_PAUSE,
        S_HEAT, S_RUN, S_COOL, S_STOP
    } ess_state_t;
endpackage : ess_pkg

//--- verilog/ess_tick_if.sv
// Second-tick carrier between the tick source and its timers
`timescale 1ns/100ps
interface ess_tick_if;
    logic sec;
    modport src (output sec);
    modport snk (input sec);
endinterface : ess_tick_if

//--- verilog/ess_tick.sv
// One-second tick divider from the system clock
`timescale 1ns/100ps
`include "ess_map.svh"
module ess_tick
#(
    parameter int TICK_CYCLES = `ESS_TICK_MS * `ESS_CLK_MHZ * `ESS_US_PER_MS
)
(
    // Tick out
    ess_tick_if.src  tk,
    // Clock and reset
    input wire logic clk,
    input wire logic rstn
);
    logic [31:0] cyc_reg;
    logic        sec_reg;
    wire         wrap = (cyc_reg == 32'(TICK_CYCLES - 1));

    // Free-running divider, one-cycle pulse per second
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cyc_reg <= 32'h0;
            sec_reg <= 1'b0;
        end
        else
        begin
            cyc_reg <= wrap ? 32'h0 : cyc_reg + 32'h1;
            sec_reg <= wrap;
        end
    end
    assign tk.sec = sec_reg;
endmodule : ess_tick

//--- verilog/ess_persist.sv
// Persistence timer: a condition must hold for limit seconds
`timescale 1ns/100ps
module ess_persist
#(
    parameter int W = 8
)
(
    // Second tick
    ess_tick_if.snk        tk,
    // Clock and reset
    input wire logic       clk,
    input wire logic       rstn,
    // Condition, limit in seconds, qualified result
    input wire logic       cond,
    input wire logic [W-1:0] limit,
    output logic           done
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;

    // Restart on any gap; counting stops at the limit so it never wraps
    assign cnt_next = !cond ? '0
                    : (tk.sec && cnt_reg < limit) ? cnt_reg + W'(1) : cnt_reg;
    assign done     = cond && (cnt_reg >= limit);

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_next;
    end
endmodule : ess_persist

//--- verilog/ess_top.sv
// Engine start/stop sequencer and speed/charge supervisor with APB registers
`timescale 1ns/100ps
`include "ess_map.svh"
module ess_top
    import ess_pkg::*;
#(
    parameter int TICK_CYCLES = `ESS_TICK_MS * `ESS_CLK_MHZ * `ESS_US_PER_MS
)
(
    // APB slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Engine and plant inputs
    input  wire logic        mains_ok,
    input  wire logic        engine_running,
    input  wire logic        speed_valid,
    input  wire logic [15:0] speed_rpm,
    input  wire logic [8:0]  charge_dv,
    input  wire logic [7:0]  coolant_c,
    input  wire logic [1:0]  freq_sel,
    input  wire logic        load_on_gen,
    input  wire logic        idle_active,
    // Relay outputs
    output logic             fuel_on,
    output logic             preheat_on,
    output logic             crank_on,
    output logic             choke_on,
    output logic             stop_on,
    output logic             load_enable,
    // Alarm outputs
    output logic             alarm_shutdown,
    output logic             alarm_loaddump,
    output logic             alarm_warning
);
    localparam logic [31:0] CFG_RV [`ESS_N_CFG] = '{
        `ESS_RV_NOM1, `ESS_RV_NOM2, `ESS_RV_NOM3, `ESS_RV_LIM, `ESS_RV_SPD,
        `ESS_RV_CHG, `ESS_RV_STC, `ESS_RV_RUN, `ESS_RV_STP};

    logic [31:0]           cfg_reg [`ESS_N_CFG];
    logic [`ESS_N_ALM-1:0] alm_reg;
    logic [`ESS_N_ALM-1:0] alm_next;
    ess_state_t            st_reg;
    ess_state_t            st_next;
    logic [9:0]            cnt_reg;
    logic [9:0]            cnt_next;
    logic [5:0]            sub_reg;
    logic [5:0]            sub_next;
    logic [7:0]            ccnt_reg;
    logic [7:0]            ccnt_next;
    logic [2:0]            att_reg;
    logic [2:0]            att_next;
    logic                  pready_reg;
    logic                  pslverr_reg;
    logic [31:0]           prdata_reg;
    logic                  fuel_reg;
    logic                  preheat_reg;
    logic                  crank_reg;
    logic                  choke_reg;
    logic                  stop_reg;
    logic                  load_reg;
    logic                  sd_reg;
    logic                  ld_reg;
    logic                  warn_reg;
    logic                  sfail;
    logic                  pfail;

    // Second tick shared by every timer
    ess_tick_if tick ();
    ess_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick
    (
        .tk   (tick),
        .clk  (pclk),
        .rstn (presetn)
    );

    // APB decode; one wait state so read data come from a flop
    wire        acc   = psel & penable;
    wire [3:0]  idx   = paddr[`ESS_F_IDX];
    wire        hit   = (paddr[`ESS_F_HI] == '0) & (paddr[`ESS_F_LO] == '0)
                      & (idx <= `ESS_I_STAT);
    wire        wr    = acc & pready_reg & pwrite & hit;
    wire        isst  = (idx == `ESS_I_STAT);
    wire [31:0] wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    wire [31:0] stat  = {13'h0, att_reg, 4'(st_reg), 3'h0, alm_reg};
    wire [31:0] rdata = !hit ? 32'h0 : isst ? stat : cfg_reg[idx];
    wire [`ESS_N_ALM-1:0] clr_v = (wr && isst) ? `ESS_N_ALM'(pwdata & wmask) : '0;

    // Bus handshake and captured read data
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0;
        end
        else
        begin
            pready_reg <= acc & ~pready_reg;
            if (acc && !pready_reg)
            begin
                prdata_reg  <= pwrite ? 32'h0 : rdata;
                pslverr_reg <= ~hit;
            end
        end
    end

    // Configuration registers, byte-lane writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < `ESS_N_CFG; i++)
                cfg_reg[i] <= CFG_RV[i];
        end
        else if (wr && idx < `ESS_I_STAT)
            cfg_reg[idx] <= (cfg_reg[idx] & ~wmask) | (pwdata & wmask);
    end

    // Configuration fields
    wire [15:0] nom1 = cfg_reg[`ESS_I_NOM1][`ESS_F_NOM];
    wire [15:0] nom2 = cfg_reg[`ESS_I_NOM2][`ESS_F_NOM];
    wire [15:0] nom3 = cfg_reg[`ESS_I_NOM3][`ESS_F_NOM];
    wire [7:0]  lw   = cfg_reg[`ESS_I_LIM][`ESS_F_LW];
    wire [7:0]  lsd  = cfg_reg[`ESS_I_LIM][`ESS_F_LSD];
    wire [7:0]  hw   = cfg_reg[`ESS_I_LIM][`ESS_F_HW];
    wire [7:0]  hsd  = cfg_reg[`ESS_I_LIM][`ESS_F_HSD];
    wire [7:0]  os   = cfg_reg[`ESS_I_SPD][`ESS_F_OS];
    wire [3:0]  sft  = cfg_reg[`ESS_I_SPD][`ESS_F_SFT];
    wire        len  = cfg_reg[`ESS_I_SPD][`ESS_F_LEN];
    wire [1:0]  act  = cfg_reg[`ESS_I_SPD][`ESS_F_ACT];
    wire [7:0]  lt   = cfg_reg[`ESS_I_SPD][`ESS_F_LT];
    wire [8:0]  cw   = cfg_reg[`ESS_I_CHG][`ESS_F_CW];
    wire [8:0]  csd  = cfg_reg[`ESS_I_CHG][`ESS_F_CSD];
    wire [6:0]  cft  = cfg_reg[`ESS_I_CHG][`ESS_F_CFT];
    wire [9:0]  dly  = cfg_reg[`ESS_I_STC][`ESS_F_DLY];
    wire [4:0]  prh  = cfg_reg[`ESS_I_STC][`ESS_F_PRH];
    wire [3:0]  crk  = cfg_reg[`ESS_I_STC][`ESS_F_CRK];
    wire [2:0]  nst  = cfg_reg[`ESS_I_STC][`ESS_F_NST];
    wire        pra  = cfg_reg[`ESS_I_STC][`ESS_F_PRA];
    wire        sta  = cfg_reg[`ESS_I_STC][`ESS_F_STA];
    wire [7:0]  pau  = cfg_reg[`ESS_I_STC][`ESS_F_WAIT];
    wire [7:0]  ht   = cfg_reg[`ESS_I_RUN][`ESS_F_HT];
    wire [7:0]  htmp = cfg_reg[`ESS_I_RUN][`ESS_F_HTMP];
    wire        hm   = cfg_reg[`ESS_I_RUN][`ESS_F_HM];
    wire [9:0]  cool = cfg_reg[`ESS_I_RUN][`ESS_F_COOL];
    wire [6:0]  stt  = cfg_reg[`ESS_I_STP][`ESS_F_ST];
    wire [7:0]  chk  = cfg_reg[`ESS_I_STP][`ESS_F_CH];

    // Speed threshold scaled by 100, a negative factor clamps at zero
    function automatic logic [25:0] thr(input logic [15:0] nom,
                                        input logic signed [9:0] pct);
        logic signed [10:0] f;
        f = `ESS_PCT + 11'(pct);
        if (f < 0)
            f = '0;
        return 26'(nom) * 26'(unsigned'(f));
    endfunction : thr

    function automatic logic signed [9:0] sx(input logic [7:0] p);
        return {{2{p[7]}}, p};
    endfunction : sx

    // Reference speed; comparing speed*100 avoids a divider
    wire [15:0] nom = (freq_sel == `ESS_FSEL_2) ? nom2
                    : (freq_sel == `ESS_FSEL_3) ? nom3 : nom1;
    wire [25:0] spd100 = 26'(speed_rpm) * 26'(`ESS_PCT);
    wire        chk_hi = load_on_gen & speed_valid;
    wire        chk_lo = chk_hi & ~idle_active;
    wire        ovr_im = chk_hi & (spd100 > thr(nom, sx(hsd) + sx(os)));
    wire        run_st = (st_reg == S_HEAT) | (st_reg == S_RUN) | (st_reg == S_COOL);

    // Raw violations fed to the persistence timers
    logic [6:0]      vio;
    logic [6:0]      done;
    logic [6:0][7:0] plim;
    assign vio[`ESS_AL_USW] = chk_lo & (spd100 < thr(nom, sx(lw)));
    assign vio[`ESS_AL_USD] = chk_lo & (spd100 < thr(nom, sx(lsd)));
    assign vio[`ESS_AL_OSW] = chk_hi & (spd100 > thr(nom, sx(hw)));
    assign vio[`ESS_AL_OSD] = chk_hi & (spd100 > thr(nom, sx(hsd)));
    assign vio[`ESS_AL_LOS] = len & run_st & ~speed_valid;
    // Charge is only judged while the engine turns, else it faults at rest
    assign vio[`ESS_AL_CHW] = engine_running & (charge_dv < cw);
    assign vio[`ESS_AL_CHD] = engine_running & (charge_dv < csd);
    assign plim = {8'(cft), 8'(cft), lt, {4{8'(sft)}}};

    genvar g;
    for (g = 0; g < 7; g++)
    begin : g_pt
        ess_persist #(.W(8)) u_pt
        (
            .tk    (tick),
            .clk   (pclk),
            .rstn  (presetn),
            .cond  (vio[g]),
            .limit (plim[g]),
            .done  (done[g])
        );
    end

    // Sticky alarms; a new event beats a software clear in the same cycle
    wire [`ESS_N_ALM-1:0] set_v = {pfail, sfail, done | (7'(ovr_im) << `ESS_AL_OSD)};
    assign alm_next = set_v | (alm_reg & ~clr_v);
    wire los    = alm_reg[`ESS_AL_LOS];
    wire sd_any = alm_reg[`ESS_AL_USD] | alm_reg[`ESS_AL_OSD] | alm_reg[`ESS_AL_CHD]
                | alm_reg[`ESS_AL_SFL] | (los & act == `ESS_ACT_SD);
    wire ld_any = los & (act == `ESS_ACT_LD);
    wire wn_any = alm_reg[`ESS_AL_USW] | alm_reg[`ESS_AL_OSW] | alm_reg[`ESS_AL_CHW]
                | alm_reg[`ESS_AL_PFL] | (los & act == `ESS_ACT_WN);
    wire active = (st_reg != S_IDLE) & (st_reg != S_STOP);

    // Sequencer
    always_comb
    begin
        st_next = st_reg;
        sfail   = 1'b0;
        pfail   = 1'b0;
        case (st_reg)
            S_IDLE:
                if (!mains_ok && !sd_any)
                    st_next = S_DELAY;
            S_DELAY:
                if (mains_ok)
                    st_next = S_IDLE;
                else if (cnt_reg >= dly)
                    st_next = S_PREHEAT;
            S_PREHEAT:
                if (cnt_reg >= 10'(prh))
                    st_next = S_CRANK;
            S_CRANK:
                if (engine_running)
                    st_next = S_HEAT;
                else if (cnt_reg >= 10'(crk))
                begin
                    if (att_reg >= nst)
                    begin
                        sfail   = 1'b1;
                        st_next = S_STOP;
                    end
                    else
                        st_next = S_PAUSE;
                end
            S_PAUSE:
                if (cnt_reg >= 10'(pau))
                    st_next = S_CRANK;
            S_HEAT:
                if (mains_ok || ld_any)
                    st_next = S_COOL;
                else if (cnt_reg >= 10'(ht) && (!hm || coolant_c >= htmp))
                    st_next = S_RUN;
            S_RUN:
                if (mains_ok || ld_any)
                    st_next = S_COOL;
            S_COOL:
                if (cnt_reg >= cool)
                    st_next = S_STOP;
                else if (!mains_ok && !ld_any)
                    st_next = S_RUN;
            S_STOP:
                if (cnt_reg >= 10'(stt))
                begin
                    pfail   = engine_running;
                    st_next = S_IDLE;
                end
            default:
                st_next = S_IDLE;
        endcase
        if (sd_any && active)
            st_next = S_STOP;
    end

    // Second counter per state; the start delay counts whole minutes
    wire sec   = tick.sec;
    wire mwrap = sec & (sub_reg == `ESS_MIN_LAST_SEC);
    wire inc   = (st_reg == S_DELAY) ? mwrap : sec;
    wire chg   = (st_next != st_reg);
    assign sub_next  = chg ? '0 : mwrap ? '0 : sub_reg + 6'(sec);
    assign cnt_next  = chg ? '0 : (cnt_reg == '1) ? cnt_reg : cnt_reg + 10'(inc);
    assign att_next  = (st_next == S_IDLE) ? '0
                     : (chg && st_next == S_CRANK) ? att_reg + 3'h1 : att_reg;
    assign ccnt_next = (st_next != S_CRANK || st_reg != S_CRANK) ? '0
                     : (ccnt_reg == '1) ? ccnt_reg : ccnt_reg + 8'(sec);

    // State and counters
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_reg   <= S_IDLE;
            cnt_reg  <= '0;
            sub_reg  <= '0;
            att_reg  <= '0;
            ccnt_reg <= '0;
            alm_reg  <= '0;
        end
        else
        begin
            st_reg   <= st_next;
            cnt_reg  <= cnt_next;
            sub_reg  <= sub_next;
            att_reg  <= att_next;
            ccnt_reg <= ccnt_next;
            alm_reg  <= alm_next;
        end
    end

    // Relay flops follow the next state so they align with it; alarm flops register the current alarms
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {fuel_reg, preheat_reg, crank_reg, choke_reg, stop_reg} <= '0;
            {load_reg, sd_reg, ld_reg, warn_reg} <= '0;
        end
        else
        begin
            fuel_reg    <= (st_next == S_PREHEAT) | (st_next == S_CRANK)
                         | (st_next == S_HEAT) | (st_next == S_RUN) | (st_next == S_COOL);
            preheat_reg <= (st_next == S_PREHEAT) & pra;
            crank_reg   <= (st_next == S_CRANK);
            choke_reg   <= (st_next == S_CRANK) & ~engine_running
                         & (ccnt_next < chk);
            stop_reg    <= (st_next == S_STOP) & sta;
            load_reg    <= (st_next == S_RUN);
            sd_reg      <= sd_any;
            ld_reg      <= ld_any;
            warn_reg    <= wn_any;
        end
    end

    assign prdata         = prdata_reg;
    assign pready         = pready_reg;
    assign pslverr        = pslverr_reg;
    assign fuel_on        = fuel_reg;
    assign preheat_on     = preheat_reg;
    assign crank_on       = crank_reg;
    assign choke_on       = choke_reg;
    assign stop_on        = stop_reg;
    assign load_enable    = load_reg;
    assign alarm_shutdown = sd_reg;
    assign alarm_loaddump = ld_reg;
    assign alarm_warning  = warn_reg;

    // Checks on the sequencer and supervisor
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    crank_len_a: assert property (st_reg == S_CRANK |-> cnt_reg <= 10'(crk))
        else $error("crank lasted beyond crank time");
    crank_fire_a: assert property (crank_reg && engine_running |=> !crank_reg)
        else $error("crank held after firing");
    fuel_delay_a: assert property (
        $rose(fuel_reg) && $past(st_reg) == S_DELAY |-> $past(cnt_reg) >= dly)
        else $error("fuel before start delay");
    stop_fail_a: assert property (
        st_reg == S_STOP && cnt_reg >= 10'(stt) && engine_running
        |=> alm_reg[`ESS_AL_PFL] && st_reg == S_IDLE)
        else $error("stop failure not flagged");
    start_fail_a: assert property (
        st_reg == S_CRANK && st_next == S_STOP && !sd_any |-> att_reg >= nst)
        else $error("start failure before last attempt");
    overshoot_a: assert property (ovr_im |=> alm_reg[`ESS_AL_OSD] ##1 sd_reg)
        else $error("overshoot not immediate");
    heat_done_a: assert property (
        $rose(load_reg) && $past(st_reg) == S_HEAT
        |-> $past(cnt_reg) >= 10'(ht) && (!hm || $past(coolant_c) >= htmp))
        else $error("load before heating done");
    sd_stop_a: assert property (sd_any && active |=> st_reg == S_STOP [*1])
        else $error("shutdown did not stop engine");
    choke_off_a: assert property (choke_reg && engine_running |=> !choke_reg)
        else $error("choke held while running");
    set_wins_a: assert property (set_v[`ESS_AL_CHW] && clr_v[`ESS_AL_CHW]
        |=> alm_reg[`ESS_AL_CHW])
        else $error("alarm lost to clear");
endmodule : ess_top

//--- bench/ess_engine_model.sv
// Behavioural engine: fires while cranked if allowed, dies on the stop relay
`timescale 1ns/100ps
module ess_engine_model
(
    // Clock
    input wire logic        clk,
    // Relays and bench controls
    input wire logic        crank_on,
    input wire logic        stop_on,
    input wire logic        will_fire,
    input wire logic [15:0] set_rpm,
    // Sensors
    output logic            running,
    output logic [15:0]     rpm,
    output logic [8:0]      chg_dv
);
    initial running = 1'b0;
    // A dead engine shows zero speed and zero charge, never the last value
    always @(posedge clk)
        if (stop_on)
            running <= 1'b0;
        else if (crank_on && will_fire)
            running <= 1'b1;
    assign rpm    = running ? set_rpm : 16'h0000;
    assign chg_dv = running ? 9'h078 : 9'h000;
endmodule : ess_engine_model

//--- bench/tb_top.sv
// Self-checking bench of the engine supervisor
`timescale 1ns/100ps
`include "ess_map.svh"
module tb_top;
    localparam int T = 20;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, mains_ok = 1, load_on_gen = 0, will_fire = 0, running;
    logic        spd_ok = 1, idle = 0;
    logic [1:0]  fsel = 2'h0;
    logic [7:0]  cool_c = 8'h00;
    logic [15:0] set_rpm = 16'h0000, rpm;
    logic [8:0]  chg;
    logic        fuel_on, preheat_on, crank_on, choke_on, stop_on, load_enable, a_sd, a_ld, a_wn;
    int          num_errors = 0, n_tests = 0, n;
    wire [8:0]   mon = {a_ld, load_enable, stop_on, choke_on, crank_on, preheat_on, fuel_on,
        a_sd, a_wn};
    logic [31:0] rv [9] = '{`ESS_RV_NOM1, `ESS_RV_NOM2, `ESS_RV_NOM3, `ESS_RV_LIM,
        `ESS_RV_SPD, `ESS_RV_CHG, `ESS_RV_STC, `ESS_RV_RUN, `ESS_RV_STP};
    always #5 pclk = ~pclk;
    ess_top #(.TICK_CYCLES(T)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .mains_ok(mains_ok),
        .engine_running(running), .speed_valid(spd_ok), .speed_rpm(rpm), .charge_dv(chg),
        .coolant_c(cool_c), .freq_sel(fsel), .load_on_gen(load_on_gen), .idle_active(idle),
        .fuel_on(fuel_on), .preheat_on(preheat_on), .crank_on(crank_on), .choke_on(choke_on),
        .stop_on(stop_on), .load_enable(load_enable), .alarm_shutdown(a_sd),
        .alarm_loaddump(a_ld), .alarm_warning(a_wn));
    ess_engine_model i_eng (.clk(pclk), .crank_on(crank_on), .stop_on(stop_on),
        .will_fire(will_fire), .set_rpm(set_rpm), .running(running), .rpm(rpm), .chg_dv(chg));
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task end_of_test;
        if (num_errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_of_test
    // Request held until pready is seen high; read data taken at that edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
        begin
            check("pready", 0, 1);
            end_of_test;
        end
    endtask : apb
    // Cycles until a watched output reaches a level; a spent bound ends the run
    task wait_bit(input int b, input logic v, input int lim);
        n = 0;
        while (mon[b] !== v && n < lim)
        begin
            @(negedge pclk);
            n++;
        end
        if (n >= lim)
        begin
            check("wait", b, 8'hff);
            end_of_test;
        end
    endtask : wait_bit
    task inr(input string s, input int lo, input int hi);
        check(s, 32'(n >= lo && n <= hi), 1);
    endtask : inr
    task reset;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
    endtask : reset
    task s_regs;
        for (int i = 0; i < 9; i++)
        begin
            apb(0, 8'(4 * i), 0);
            check("reset value", rd, rv[i]);
        end
        apb(0, 8'h28, 0);
        check("unmapped", {rd[30:0], er}, 1);
    endtask : s_regs
    // Engine never fires: two timed attempts with a pause, then start failure
    task s_fail;
        apb(1, 8'h18, 32'h01d1_0800);
        @(posedge pclk) mains_ok <= 1'b0;
        wait_bit(2, 1, 100);
        check("preheat", preheat_on, 1);
        wait_bit(4, 1, 3 * T);
        inr("preheat time", T, 2 * T + 3);
        check("choke", choke_on, 1);
        wait_bit(4, 0, 3 * T);
        inr("crank time", T, 2 * T + 3);
        wait_bit(4, 1, 2 * T);
        inr("pause", 0, T + 3);
        wait_bit(4, 0, 3 * T);
        wait_bit(6, 1, 5);
        apb(0, 8'h24, 0);
        check("start fail", {rd[18:16], rd[7]}, 4'h5);
        @(posedge pclk) mains_ok <= 1'b1;
    endtask : s_fail
    // Engine fires, heats, takes load, then over-revs
    task s_run;
        apb(1, 8'h18, 32'h0adb_0000);
        @(posedge pclk);
        will_fire <= 1'b1;
        set_rpm <= 16'd1500;
        mains_ok <= 1'b0;
        wait_bit(4, 1, 100);
        wait_bit(4, 0, 10);
        check("choke off", choke_on, 0);
        wait_bit(7, 1, 5 * T);
        inr("heating", 3 * T, 4 * T + 3);
        @(posedge pclk);
        load_on_gen <= 1'b1;
        set_rpm <= 16'd1660;
        wait_bit(0, 1, 4 * T);
        inr("overspeed warn", 2 * T, 3 * T + 4);
        @(posedge pclk) set_rpm <= 16'd1900;
        wait_bit(1, 1, 5);
        wait_bit(6, 1, 5);
        check("shutdown", a_sd, 1);
    endtask : s_run
    // Second nominal, idle masking, heating to temperature, lost signal dump, cooldown
    task s_sel;
        @(posedge pclk) {mains_ok, load_on_gen} <= 2'b10;
        apb(1, 8'h18, 32'h0adb_0000);
        apb(1, 8'h1c, 32'h0007_3204);
        apb(1, 8'h10, 32'h0000_330a);
        @(posedge pclk);
        will_fire <= 1'b1;
        set_rpm <= 16'd1600;
        fsel <= 2'h1;
        idle <= 1'b1;
        mains_ok <= 1'b0;
        wait_bit(4, 1, 100);
        wait_bit(4, 0, 10);
        repeat (6 * T) @(negedge pclk);
        check("heat temp", load_enable, 0);
        @(posedge pclk) cool_c <= 8'd60;
        wait_bit(7, 1, 5);
        @(posedge pclk) load_on_gen <= 1'b1;
        repeat (5 * T) @(negedge pclk);
        check("idle mask", a_wn, 0);
        @(posedge pclk) idle <= 1'b0;
        wait_bit(0, 1, 4 * T);
        inr("underspeed warn", 2 * T, 3 * T + 4);
        @(posedge pclk) spd_ok <= 1'b0;
        wait_bit(8, 1, 5);
        wait_bit(7, 0, 5);
        wait_bit(6, 1, 4 * T);
        inr("cooldown", 2 * T, 3 * T + 4);
    endtask : s_sel
    initial
    begin
        reset;
        s_regs;
        s_fail;
        reset;
        s_run;
        reset;
        s_sel;
        end_of_test;
    end
endmodule : tb_top
